// ===== swf_status_word.sv
// Purpose: status word flags of an 8-bit core, updated by datapath and software
// Assumes: one datapath strobe per cycle; software on APB
// Notes: for DA the aux flag is passed on op_b[0]
// Function
// - add sets carry on carry out of bit 7; subtract on borrow into it
// - multiply and divide always leave carry cleared
// - decimal adjust sets carry when the decimal sum reaches a hundred
// - compare-jump sets carry when first unsigned operand is below second
// - aux carry follows carry out of or borrow into low nibble bit 4
// - status word at D0h, bit layout fixed, parity read-only
// - overflow set when carries out of bits 6 and 7 differ
// - multiply overflow above 255; divide overflow only for zero divisor
// - parity always equals odd count of ones in the accumulator
// - two bank bits select one of four register banks
`timescale 1ns/1ns
module swf_status_word (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // datapath
   input wire logic op_valid,
   input wire swf_pkg::swf_req_t op_req,
   input wire logic acc_we,
   input wire logic [7:0] acc_wdata,
   // results
   output logic [7:0] op_result,
   output logic [7:0] status_word,
   output logic [7:0] accumulator,
   output logic [4:0] bank_base
);
   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   typedef struct packed {
      logic [7:0] program_status_word;
      logic [7:0] acc;
      logic [7:0] result;
      logic [31:0] rdata;
      logic ready;
      logic err;
   } swf_state_t;

   swf_state_t state_reg;
   swf_state_t state_next;
   swf_pkg::swf_res_t alu_res;
   logic [7:0] acc_new;
   logic bus_hit;

   function automatic logic odd_ones(input logic [7:0] v);
      return ^v;
   endfunction

   swf_alu u_alu (
      .req(op_req),
      .carry_in(state_reg.program_status_word[swf_pkg::CARRY_POS]),
      .res(alu_res)
   );

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      acc_new = state_reg.acc;
      bus_hit = paddr[11:0] == {4'h0, swf_pkg::STATUS_WORD_OFFSET};
      state_next.ready = 1'b0;
      state_next.err = 1'b0;
      if (op_valid && op_req.op != swf_pkg::SWF_OP_NONE) begin
         state_next.program_status_word[swf_pkg::CARRY_POS] = alu_res.carry;
         if (op_req.op inside {swf_pkg::SWF_OP_ADD, swf_pkg::SWF_OP_ADD_WITH_CARRY_OP, swf_pkg::SWF_OP_SUBTRACT_WITH_BORROW_OP}) begin
            state_next.program_status_word[swf_pkg::AUX_POS] = alu_res.aux;
         end
         if (op_req.op inside {swf_pkg::SWF_OP_ADD, swf_pkg::SWF_OP_ADD_WITH_CARRY_OP, swf_pkg::SWF_OP_SUBTRACT_WITH_BORROW_OP,
                               swf_pkg::SWF_OP_MUL, swf_pkg::SWF_OP_DIV}) begin
            state_next.program_status_word[swf_pkg::OVF_POS] = alu_res.ovf;
         end
         if (op_req.op != swf_pkg::SWF_OP_COMPARE_JUMP_NOT_EQUAL_OP) begin
            acc_new = alu_res.result;
         end
         state_next.result = alu_res.result;
      end
      if (acc_we) begin
         acc_new = acc_wdata;
      end
      // software write lands after the datapath, so it wins a same-cycle clash
      if (psel && !penable) begin
         state_next.ready = 1'b1;
         state_next.err = !bus_hit;
         state_next.rdata = bus_hit ? {24'h000000, state_reg.program_status_word[7:1], odd_ones(state_reg.acc)} : 32'h00000000;
      end
      if (psel && penable && pready && pwrite && bus_hit && pstrb[0]) begin
         state_next.program_status_word[7:1] = pwdata[7:1];
      end
      state_next.acc = acc_new;
      state_next.program_status_word[swf_pkg::PARITY_POS] = odd_ones(acc_new);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '{program_status_word: swf_pkg::STATUS_RESET, acc: swf_pkg::ACC_RESET, result: 8'h00,
                        rdata: 32'h00000000, ready: 1'b0, err: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign prdata = state_reg.rdata;
   assign pready = state_reg.ready;
   assign pslverr = state_reg.err;
   assign op_result = state_reg.result;
   assign status_word = state_reg.program_status_word;
   assign accumulator = state_reg.acc;
   // bank base address: bank times eight
   assign bank_base = {state_reg.program_status_word[swf_pkg::BANK_HI_POS:swf_pkg::BANK_LO_POS], 3'b000};

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   sequence s_mul_op;
      op_valid && op_req.op == swf_pkg::SWF_OP_MUL && !(psel && penable && pwrite);
   endsequence

   sequence s_add_op;
      op_valid && op_req.op == swf_pkg::SWF_OP_ADD && !(psel && penable && pwrite);
   endsequence

   sequence s_add_with_carry_op_op;
      op_valid && op_req.op == swf_pkg::SWF_OP_ADD_WITH_CARRY_OP && !(psel && penable && pwrite);
   endsequence

   sequence s_subtract_with_borrow_op_op;
      op_valid && op_req.op == swf_pkg::SWF_OP_SUBTRACT_WITH_BORROW_OP && !(psel && penable && pwrite);
   endsequence

   sequence s_div_op;
      op_valid && op_req.op == swf_pkg::SWF_OP_DIV && !(psel && penable && pwrite);
   endsequence

   // a start value above 99 or a carry already set must leave carry set
   sequence s_da_big;
      op_valid && op_req.op == swf_pkg::SWF_OP_DA && !(psel && penable && pwrite)
      && (status_word[swf_pkg::CARRY_POS] || op_req.a > 8'h99);
   endsequence

   // these ops leave the aux flag alone
   sequence s_no_aux_op;
      op_valid && op_req.op inside {swf_pkg::SWF_OP_MUL, swf_pkg::SWF_OP_DIV, swf_pkg::SWF_OP_DA,
                                    swf_pkg::SWF_OP_COMPARE_JUMP_NOT_EQUAL_OP} && !(psel && penable && pwrite);
   endsequence

   sequence s_setup_hit;
      psel && !penable && paddr == {4'h0, swf_pkg::STATUS_WORD_OFFSET};
   endsequence

   sequence s_setup_miss;
      psel && !penable && paddr != {4'h0, swf_pkg::STATUS_WORD_OFFSET};
   endsequence

   // reference sums kept apart from the datapath so a shared slip cannot hide
   logic [7:0] chk_add_sum;
   logic [7:0] chk_sub_diff;

   assign chk_add_sum = op_req.a + op_req.b;
   assign chk_sub_diff = op_req.a - op_req.b - {7'h00, status_word[swf_pkg::CARRY_POS]};

   AST_PARITY: assert property (@(posedge pclk) disable iff (!presetn)
      status_word[0] == ^accumulator) else $error("parity mismatch");
   AST_ADD_CARRY: assert property (@(posedge pclk) disable iff (!presetn)
      op_valid && op_req.op == swf_pkg::SWF_OP_ADD && !(psel && penable && pwrite)
      |=> status_word[7] == $past({1'b0, op_req.a} + {1'b0, op_req.b} > 9'h0FF)) else $error("add carry");
   AST_MUL_CARRY: assert property (@(posedge pclk) disable iff (!presetn)
      s_mul_op |=> !status_word[7]) else $error("mul carry not clear");
   AST_MUL_OVF: assert property (@(posedge pclk) disable iff (!presetn)
      s_mul_op |=> status_word[2] == ($past(op_req.a) * $past(op_req.b) > 255)) else $error("mul ovf");
   AST_COMPARE_JUMP_NOT_EQUAL_OP: assert property (@(posedge pclk) disable iff (!presetn)
      op_valid && op_req.op == swf_pkg::SWF_OP_COMPARE_JUMP_NOT_EQUAL_OP && !(psel && penable && pwrite)
      |=> status_word[7] == $past(op_req.a < op_req.b)) else $error("compare_jump_not_equal_op carry");
   AST_DIV_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      op_valid && op_req.op == swf_pkg::SWF_OP_DIV && op_req.b == 8'h00 && !(psel && penable && pwrite)
      |=> status_word[2] && !status_word[7]) else $error("div zero");
   AST_USER_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && penable && pwrite) |=> $stable({status_word[5], status_word[1]})) else $error("user flag moved");
   AST_SW_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pready && pwrite && paddr == 12'h0D0 && pstrb[0]
      |=> status_word[7:1] == $past(pwdata[7:1])) else $error("write lost");
   AST_BANK: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pready && pwrite && paddr == 12'h0D0 && pstrb[0]
      |=> bank_base == {$past(pwdata[4:3]), 3'b000}) else $error("bank base");
   AST_ADD_WITH_CARRY_OP_CARRY: assert property (@(posedge pclk) disable iff (!presetn)
      s_add_with_carry_op_op |=> status_word[7] == $past({1'b0, op_req.a} + {1'b0, op_req.b} + {8'h00, status_word[7]} > 9'h0FF))
      else $error("add_with_carry_op carry");
   AST_SUBTRACT_WITH_BORROW_OP_CARRY: assert property (@(posedge pclk) disable iff (!presetn)
      s_subtract_with_borrow_op_op |=> status_word[7] == $past({1'b0, op_req.a} < {1'b0, op_req.b} + {8'h00, status_word[7]}))
      else $error("subtract_with_borrow_op borrow");
   AST_ADD_AUX: assert property (@(posedge pclk) disable iff (!presetn)
      s_add_op |=> status_word[6] == $past({1'b0, op_req.a[3:0]} + {1'b0, op_req.b[3:0]} > 5'h0F))
      else $error("add aux");
   AST_SUBTRACT_WITH_BORROW_OP_AUX: assert property (@(posedge pclk) disable iff (!presetn)
      s_subtract_with_borrow_op_op |=> status_word[6] == $past({1'b0, op_req.a[3:0]} < {1'b0, op_req.b[3:0]} + {4'h0, status_word[7]}))
      else $error("subtract_with_borrow_op aux");
   AST_AUX_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      s_no_aux_op |=> $stable(status_word[6])) else $error("aux moved");
   AST_ADD_OVF: assert property (@(posedge pclk) disable iff (!presetn)
      s_add_op |=> status_word[2] == $past(op_req.a[7] == op_req.b[7] && chk_add_sum[7] != op_req.a[7]))
      else $error("add ovf");
   AST_SUBTRACT_WITH_BORROW_OP_OVF: assert property (@(posedge pclk) disable iff (!presetn)
      s_subtract_with_borrow_op_op |=> status_word[2] == $past(op_req.a[7] != op_req.b[7] && chk_sub_diff[7] != op_req.a[7]))
      else $error("subtract_with_borrow_op ovf");
   AST_DA_CARRY: assert property (@(posedge pclk) disable iff (!presetn)
      s_da_big |=> status_word[7]) else $error("da carry");
   AST_DIV_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      s_div_op |=> !status_word[7] && status_word[2] == $past(op_req.b == 8'h00)) else $error("div flags");
   AST_PRDATA: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup_hit |=> pready && !pslverr && prdata == {24'h000000, $past(status_word)}) else $error("read data");
   AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup_miss |=> pready && pslverr && prdata == 32'h00000000) else $error("unmapped access");
   AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready) else $error("pready held");
endmodule

// ===== swf_pkg.sv
// Purpose: shared constants and types for the status word flag logic
// Assumes: 8-bit data path, APB with 32-bit data
// Notes: status word sits at the printed byte offset on the bus
package swf_pkg;
   localparam logic [7:0] STATUS_WORD_OFFSET = 8'hD0;
   localparam int CARRY_POS = 7;
   localparam int AUX_POS = 6;
   localparam int UF0_POS = 5;
   localparam int BANK_HI_POS = 4;
   localparam int BANK_LO_POS = 3;
   localparam int OVF_POS = 2;
   localparam int UF1_POS = 1;
   localparam int PARITY_POS = 0;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [8:0] BCD_LIMIT = 9'h064;
   localparam logic [15:0] PRODUCT_LIMIT = 16'h00FF;

   typedef enum logic [3:0] {
      SWF_OP_NONE = 4'h0,
      SWF_OP_ADD = 4'h1,
      SWF_OP_ADD_WITH_CARRY_OP = 4'h2,
      SWF_OP_SUBTRACT_WITH_BORROW_OP = 4'h3,
      SWF_OP_MUL = 4'h4,
      SWF_OP_DIV = 4'h5,
      SWF_OP_DA = 4'h6,
      SWF_OP_COMPARE_JUMP_NOT_EQUAL_OP = 4'h7
   } swf_op_t;

   typedef struct packed {
      swf_op_t op;
      logic [7:0] a;
      logic [7:0] b;
   } swf_req_t;

   typedef struct packed {
      logic carry;
      logic aux;
      logic ovf;
      logic [7:0] result;
   } swf_res_t;
endpackage

// ===== swf_alu.sv
// Purpose: combinational flag computation for one datapath operation
// Assumes: operands stable for the cycle of the strobe
// Notes: no state; the top registers the outcome
`timescale 1ns/1ns
module swf_alu (
   // request
   input wire swf_pkg::swf_req_t req,
   input wire logic carry_in,
   // outcome
   output swf_pkg::swf_res_t res
);
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] c6;
   logic [15:0] prod;
   logic [8:0] adj;

   always_comb begin
      res = '0;
      sum = '0;
      nib = '0;
      c6 = '0;
      prod = '0;
      adj = '0;
      unique case (req.op)
         swf_pkg::SWF_OP_ADD, swf_pkg::SWF_OP_ADD_WITH_CARRY_OP: begin
            sum = {1'b0, req.a} + {1'b0, req.b} + {8'h00, (req.op == swf_pkg::SWF_OP_ADD_WITH_CARRY_OP) & carry_in};
            nib = {1'b0, req.a[3:0]} + {1'b0, req.b[3:0]} + {4'h0, (req.op == swf_pkg::SWF_OP_ADD_WITH_CARRY_OP) & carry_in};
            c6 = {1'b0, req.a[6:0]} + {1'b0, req.b[6:0]} + {7'h00, (req.op == swf_pkg::SWF_OP_ADD_WITH_CARRY_OP) & carry_in};
            res.carry = sum[8];
            res.aux = nib[4];
            res.ovf = sum[8] ^ c6[7];
            res.result = sum[7:0];
         end
         swf_pkg::SWF_OP_SUBTRACT_WITH_BORROW_OP: begin
            sum = {1'b0, req.a} - {1'b0, req.b} - {8'h00, carry_in};
            nib = {1'b0, req.a[3:0]} - {1'b0, req.b[3:0]} - {4'h0, carry_in};
            c6 = {1'b0, req.a[6:0]} - {1'b0, req.b[6:0]} - {7'h00, carry_in};
            res.carry = sum[8];
            res.aux = nib[4];
            res.ovf = sum[8] ^ c6[7];
            res.result = sum[7:0];
         end
         swf_pkg::SWF_OP_MUL: begin
            prod = req.a * req.b;
            res.carry = 1'b0;
            res.ovf = prod > swf_pkg::PRODUCT_LIMIT;
            res.result = prod[7:0];
         end
         swf_pkg::SWF_OP_DIV: begin
            res.carry = 1'b0;
            res.ovf = (req.b == 8'h00);
            res.result = (req.b == 8'h00) ? 8'hFF : req.a / req.b;
         end
         swf_pkg::SWF_OP_DA: begin
            adj = {1'b0, req.a};
            if (adj[3:0] > 4'h9 || req.b[0]) begin
               adj = adj + 9'h006;
            end
            if (adj[7:4] > 4'h9 || adj[8] || carry_in) begin
               adj = adj + 9'h060;
            end
            // carry marks a decimal sum of a hundred or more
            res.carry = adj[8] | carry_in;
            res.result = adj[7:0];
         end
         swf_pkg::SWF_OP_COMPARE_JUMP_NOT_EQUAL_OP: begin
            res.carry = req.a < req.b;
         end
         default: begin
            res = '0;
         end
      endcase
   end
endmodule

// ===== tb.sv
// Purpose: self-checking bench for the status word flag logic
// Assumes: APB slave answers on its own; one datapath op per strobe
// Notes: flags are compared under a mask so untouched bits must hold
`timescale 1ns/1ns
module tb;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic op_valid = 1'b0;
   swf_pkg::swf_req_t op_req = '0;
   logic acc_we = 1'b0;
   logic [7:0] acc_wdata = 8'h00;
   logic [7:0] op_result;
   logic [7:0] status_word;
   logic [7:0] accumulator;
   logic [4:0] bank_base;
   logic [31:0] rd;
   logic err;
   logic [7:0] pv [3] = '{8'h07, 8'h03, 8'h80};
   int n_mismatch = 0;
   int n_tests = 0;

   always #2 pclk = ~pclk;

   swf_status_word swf_status_word_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .op_valid(op_valid), .op_req(op_req), .acc_we(acc_we), .acc_wdata(acc_wdata),
      .op_result(op_result), .status_word(status_word), .accumulator(accumulator), .bank_base(bank_base));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd, input logic [3:0] strb);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      pstrb <= strb;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         chk("pready", {31'h0, pready}, 32'h1);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // e and m are {carry, aux, overflow}; user flags and bank must stay at 0x32
   task automatic do_op(input swf_pkg::swf_op_t o, input logic [7:0] a, input logic [7:0] b,
                        input logic [2:0] e, input logic [2:0] m);
      logic [7:0] em;
      logic [7:0] ev;
      em = {m[2], m[1], 3'b000, m[0], 2'b00} | 8'h3A;
      ev = {e[2], e[1], 3'b000, e[0], 2'b00} | 8'h32;
      @(posedge pclk);
      op_valid <= 1'b1;
      op_req <= '{op: o, a: a, b: b};
      @(posedge pclk);
      op_valid <= 1'b0;
      #1;
      chk("status_flags", {24'h0, status_word & em}, {24'h0, ev & em});
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      #40000;
      n_mismatch++;
      $display("mismatch watchdog expired");
      close_out();
   end

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h0D0, 32'h0, 4'hF);
      chk("reset_word", rd, 32'h0);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 12'h0D0, 32'(i << 3), 4'hF);
         @(posedge pclk);
         #1;
         chk("bank_base", {27'h0, bank_base}, 32'(i * 8));
      end
      apb(1'b1, 12'h0D0, 32'hFF, 4'hF);
      apb(1'b0, 12'h0D0, 32'h0, 4'hF);
      chk("ro_parity", rd, 32'hFE);
      apb(1'b1, 12'h0D0, 32'h32, 4'h0);
      apb(1'b1, 12'h0D4, 32'h00, 4'hF);
      chk("unmapped_err", {31'h0, err}, 32'h1);
      apb(1'b0, 12'h0D0, 32'h0, 4'hF);
      chk("ignored_writes", rd, 32'hFE);
      apb(1'b0, 12'h0D4, 32'h0, 4'hF);
      chk("unmapped_rd", rd, 32'h0);
      apb(1'b1, 12'h0D0, 32'hFFFFFF32, 4'hF);
      apb(1'b0, 12'h0D0, 32'h0, 4'hF);
      chk("word_rd", rd, 32'h32);
      do_op(swf_pkg::SWF_OP_ADD, 8'h7F, 8'h01, 3'b011, 3'b111);
      chk("op_result", {24'h0, op_result}, 32'h80);
      do_op(swf_pkg::SWF_OP_ADD, 8'hFF, 8'h01, 3'b110, 3'b111);
      do_op(swf_pkg::SWF_OP_ADD_WITH_CARRY_OP, 8'h0E, 8'h01, 3'b010, 3'b111);
      do_op(swf_pkg::SWF_OP_SUBTRACT_WITH_BORROW_OP, 8'h80, 8'h01, 3'b011, 3'b111);
      do_op(swf_pkg::SWF_OP_SUBTRACT_WITH_BORROW_OP, 8'h00, 8'h01, 3'b110, 3'b111);
      do_op(swf_pkg::SWF_OP_SUBTRACT_WITH_BORROW_OP, 8'h05, 8'h01, 3'b000, 3'b111);
      do_op(swf_pkg::SWF_OP_COMPARE_JUMP_NOT_EQUAL_OP, 8'h03, 8'h05, 3'b100, 3'b100);
      do_op(swf_pkg::SWF_OP_MUL, 8'h10, 8'h10, 3'b001, 3'b101);
      do_op(swf_pkg::SWF_OP_MUL, 8'h0F, 8'h11, 3'b000, 3'b101);
      do_op(swf_pkg::SWF_OP_DA, 8'hA0, 8'h00, 3'b100, 3'b100);
      do_op(swf_pkg::SWF_OP_COMPARE_JUMP_NOT_EQUAL_OP, 8'h05, 8'h03, 3'b000, 3'b100);
      do_op(swf_pkg::SWF_OP_DA, 8'h45, 8'h00, 3'b000, 3'b100);
      do_op(swf_pkg::SWF_OP_DIV, 8'h05, 8'h00, 3'b001, 3'b101);
      do_op(swf_pkg::SWF_OP_DIV, 8'h09, 8'h03, 3'b000, 3'b101);
      foreach (pv[i]) begin
         @(posedge pclk);
         acc_we <= 1'b1;
         acc_wdata <= pv[i];
         @(posedge pclk);
         acc_we <= 1'b0;
         #1;
         chk("parity", {31'h0, status_word[0]}, {31'h0, ^pv[i]});
      end
      chk("accumulator", {24'h0, accumulator}, 32'h80);
      // second reset in mid-run must clear a non-zero word
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      #1;
      chk("reset_mid", {24'h0, status_word}, 32'h0);
      apb(1'b0, 12'h0D0, 32'h0, 4'hF);
      chk("reset_rd", rd, 32'h0);
      close_out();
   end
endmodule
